// [design/apt_pkg.sv]
// Package of offsets, field positions, reset values and counts for the aux pin and PCM port.
`default_nettype none
package apt_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [11:0] OFS_GPIO_DIR = 12'h000;
   localparam logic [11:0] OFS_GPIO_OUT = 12'h004;
   localparam logic [11:0] OFS_GPIO_OD = 12'h008;
   localparam logic [11:0] OFS_GPIO_IN = 12'h00c;
   localparam logic [11:0] OFS_PCM_CTRL = 12'h010;
   localparam logic [11:0] OFS_CH0_CFG = 12'h014;
   localparam logic [11:0] OFS_CH1_CFG = 12'h018;
   localparam logic [11:0] OFS_IRQ_MODE = 12'h01c;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h020;
   localparam logic [11:0] OFS_TOP_IRQ_STATUS = 12'h024;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FBMODE_BIT = 1;
   localparam int CTRL_TEST_BIT = 2;
   localparam int CFG_BUS_LSB = 0;
   localparam int CFG_TX_LSB = 4;
   localparam int CFG_RX_LSB = 8;
   localparam int CFG_EN_BIT = 12;
   localparam int IRQ_STAT_LSB = 6;
   localparam int IRQ_PIN_LSB = 3;
   localparam int PIN_RX = 1;

   // ****************************************
   // Widths and pin roles
   // ****************************************
   localparam int NUM_PINS = 5;
   localparam int NUM_CH = 2;
   localparam logic [4:0] PCM_PINS = 5'h07;
   localparam logic [4:0] PCM_OE_PINS = 5'h05;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [4:0] RST_GPIO = 5'h00;
   localparam logic [2:0] RST_CTRL = 3'h0;
   localparam logic [12:0] RST_CH0_CFG = 13'h0000;
   localparam logic [12:0] RST_CH1_CFG = 13'h0001;
   localparam logic [1:0] RST_IRQ_MODE = 2'h0;
   localparam logic [1:0] RST_IRQ_MASK = 2'h3;

   // ****************************************
   // Clock divider counts, in double-rate clock edges
   // ****************************************
   localparam logic [7:0] FSO_DIV = 8'hc0;
   localparam logic [7:0] FSO_HIGH = 8'h02;
endpackage : apt_pkg
`default_nettype wire

// [design/apt_aux_pcm.sv]
// Auxiliary pins, PCM timeslot switch and aux interrupt logic with an APB register slave.
`default_nettype none
module apt_aux_pcm (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Auxiliary pins, bit 0 frame sync or bit clock out, 1 receive, 2 transmit, 3 and 4 interrupt capable
   input wire logic [4:0] AUX_PIN_IN,
   output logic [4:0] AUX_PIN_OUT,
   output logic [4:0] AUX_PIN_OE,
   // Shared serial bus timing
   input wire logic DOUBLE_RATE_BIT_CLOCK,
   input wire logic FRAME_SYNC,
   // Serial bus data lines
   input wire logic SERIAL_DOWNSTREAM_DATA_IN,
   output logic SERIAL_DOWNSTREAM_DATA_OUT,
   output logic SERIAL_DOWNSTREAM_DATA_OE,
   input wire logic SERIAL_UPSTREAM_DATA_IN,
   output logic SERIAL_UPSTREAM_DATA_OUT,
   output logic SERIAL_UPSTREAM_DATA_OE,
   // Host interrupt
   output logic IRQ_N
);

   // ****************************************
   // Reset release and input synchronisers
   // ****************************************
   logic [1:0] rst_sync_ff;
   logic rst_n;
   logic [8:0] in_meta_ff, in_sync_ff, in_raw;

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // Every pin input is asynchronous to the system clock, so all pass two flops.
   // The aux bits reset to the idle high level, so leaving reset cannot look like an interrupt.
   assign in_raw = {SERIAL_UPSTREAM_DATA_IN, SERIAL_DOWNSTREAM_DATA_IN, FRAME_SYNC,
                    DOUBLE_RATE_BIT_CLOCK, AUX_PIN_IN};
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         in_meta_ff <= 9'h01f;
         in_sync_ff <= 9'h01f;
      end else begin
         in_meta_ff <= in_raw;
         in_sync_ff <= in_meta_ff;
      end
   end

   logic [4:0] aux_s;
   logic dcl_s, fsc_s, dd_s, du_s;
   assign aux_s = in_sync_ff[4:0];
   assign dcl_s = in_sync_ff[5];
   assign fsc_s = in_sync_ff[6];
   assign dd_s = in_sync_ff[7];
   assign du_s = in_sync_ff[8];

   // ****************************************
   // Registers and APB decode
   // ****************************************
   logic [4:0] dir_ff, out_ff, od_ff;
   logic [2:0] ctrl_ff;
   logic [12:0] cfg0_ff, cfg1_ff;
   logic [1:0] irq_mode_ff, mask_ff, pend_ff, stat_vis;
   logic [31:0] prdata_ff, rd_mux;

   logic setup_ph, wr_done, rd_done, addr_ok;
   logic sel_dir, sel_out, sel_od, sel_in, sel_ctrl, sel_cfg0, sel_cfg1, sel_mode, sel_mask, sel_stat;

   assign setup_ph = PSEL & ~PENABLE;
   assign wr_done = PSEL & PENABLE & PWRITE;
   assign rd_done = PSEL & PENABLE & ~PWRITE;
   assign sel_dir = PADDR == apt_pkg::OFS_GPIO_DIR;
   assign sel_out = PADDR == apt_pkg::OFS_GPIO_OUT;
   assign sel_od = PADDR == apt_pkg::OFS_GPIO_OD;
   assign sel_in = PADDR == apt_pkg::OFS_GPIO_IN;
   assign sel_ctrl = PADDR == apt_pkg::OFS_PCM_CTRL;
   assign sel_cfg0 = PADDR == apt_pkg::OFS_CH0_CFG;
   assign sel_cfg1 = PADDR == apt_pkg::OFS_CH1_CFG;
   assign sel_mode = PADDR == apt_pkg::OFS_IRQ_MODE;
   assign sel_mask = PADDR == apt_pkg::OFS_IRQ_MASK;
   assign sel_stat = PADDR == apt_pkg::OFS_TOP_IRQ_STATUS;
   assign addr_ok = sel_dir | sel_out | sel_od | sel_in | sel_ctrl | sel_cfg0 | sel_cfg1 |
                    sel_mode | sel_mask | sel_stat;
   assign stat_vis = pend_ff & ~mask_ff;

   // The pin level is taken in the setup cycle of the read itself.
   assign rd_mux = sel_dir ? {27'h0, dir_ff} :
                   sel_out ? {27'h0, out_ff} :
                   sel_od ? {27'h0, od_ff} :
                   sel_in ? {27'h0, aux_s} :
                   sel_ctrl ? {29'h0, ctrl_ff} :
                   sel_cfg0 ? {19'h0, cfg0_ff} :
                   sel_cfg1 ? {19'h0, cfg1_ff} :
                   sel_mode ? {30'h0, irq_mode_ff} :
                   sel_mask ? {24'h0, mask_ff, 6'h00} :
                   sel_stat ? {24'h0, stat_vis, 6'h00} :
                   32'h0;

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0;
      end else if (setup_ph) begin
         prdata_ff <= rd_mux;
      end
   end

   // Reset leaves every pin an input, the PCM port off and both interrupts masked.
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         dir_ff <= apt_pkg::RST_GPIO;
         out_ff <= apt_pkg::RST_GPIO;
         od_ff <= apt_pkg::RST_GPIO;
         ctrl_ff <= apt_pkg::RST_CTRL;
         cfg0_ff <= apt_pkg::RST_CH0_CFG;
         cfg1_ff <= apt_pkg::RST_CH1_CFG;
         irq_mode_ff <= apt_pkg::RST_IRQ_MODE;
         mask_ff <= apt_pkg::RST_IRQ_MASK;
      end else if (wr_done) begin
         if (sel_dir) begin
            dir_ff <= PWDATA[4:0];
         end else if (sel_out) begin
            out_ff <= PWDATA[4:0];
         end else if (sel_od) begin
            od_ff <= PWDATA[4:0];
         end else if (sel_ctrl) begin
            ctrl_ff <= PWDATA[2:0];
         end else if (sel_cfg0) begin
            cfg0_ff <= PWDATA[12:0];
         end else if (sel_cfg1) begin
            cfg1_ff <= PWDATA[12:0];
         end else if (sel_mode) begin
            irq_mode_ff <= PWDATA[1:0];
         end else if (sel_mask) begin
            mask_ff <= PWDATA[7:6];
         end
      end
   end

   assign PRDATA = prdata_ff;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~addr_ok;

   logic pcm_en, fb_bitclk, test_rev;
   assign pcm_en = ctrl_ff[apt_pkg::CTRL_EN_BIT];
   assign fb_bitclk = ctrl_ff[apt_pkg::CTRL_FBMODE_BIT];
   assign test_rev = ctrl_ff[apt_pkg::CTRL_TEST_BIT];

   // ****************************************
   // Aux pin interrupts
   // ****************************************
   logic [1:0] irq_lvl_prev_ff, irq_src, irq_ev, irq_clr, nxt_pend;
   logic int_n_ff;

   assign irq_src = aux_s[apt_pkg::IRQ_PIN_LSB +: 2];
   // Active low sources: edge mode takes the falling edge, level mode the low level.
   assign irq_ev = ~dir_ff[apt_pkg::IRQ_PIN_LSB +: 2] &
                   ((irq_mode_ff & irq_lvl_prev_ff & ~irq_src) | (~irq_mode_ff & ~irq_src));
   // Reading the status clears the unmasked bits pending in its access cycle; masked ones stay pending.
   assign irq_clr = (rd_done & sel_stat) ? stat_vis : 2'h0;
   // A new event in the clearing cycle wins over the clear.
   assign nxt_pend = irq_ev | (pend_ff & ~irq_clr);

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         irq_lvl_prev_ff <= 2'h3;
         pend_ff <= 2'h0;
         int_n_ff <= 1'b1;
      end else begin
         irq_lvl_prev_ff <= irq_src;
         pend_ff <= nxt_pend;
         int_n_ff <= ~|(nxt_pend & ~mask_ff);
      end
   end
   assign IRQ_N = int_n_ff;

   // ****************************************
   // Frame timing from the shared clock and sync
   // ****************************************
   logic dcl_prev_ff, fsc_prev_ff, dcl_rise, fsc_rise, sample_ev, drive_ev;
   logic [7:0] dcl_cnt_ff, nxt_dcl_cnt;
   logic [3:0] smp_slot, drv_slot;
   logic [2:0] drv_bit;

   assign dcl_rise = dcl_s & ~dcl_prev_ff;
   assign fsc_rise = fsc_s & ~fsc_prev_ff;
   // Both the PCM port and the serial bus count from the same sync edge.
   assign nxt_dcl_cnt = fsc_rise ? 8'h00 : (dcl_rise ? dcl_cnt_ff + 8'h01 : dcl_cnt_ff);
   // Two double-rate edges per bit: drive on the first, sample on the second.
   assign sample_ev = dcl_rise & ~fsc_rise & ~dcl_cnt_ff[0];
   assign drive_ev = fsc_rise | (dcl_rise & dcl_cnt_ff[0]);
   assign smp_slot = dcl_cnt_ff[7:4];
   assign drv_slot = nxt_dcl_cnt[7:4];
   assign drv_bit = nxt_dcl_cnt[3:1];

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         dcl_prev_ff <= 1'b0;
         fsc_prev_ff <= 1'b0;
         dcl_cnt_ff <= 8'h00;
      end else begin
         dcl_prev_ff <= dcl_s;
         fsc_prev_ff <= fsc_s;
         dcl_cnt_ff <= nxt_dcl_cnt;
      end
   end

   // ****************************************
   // Timeslot switch, one generate entry per B-channel
   // ****************************************
   logic [12:0] cfg [apt_pkg::NUM_CH];
   logic [1:0] tx_hit, tx_bit, bus_hit, bus_bit;
   logic dn_src, rx_line;

   assign cfg[0] = cfg0_ff;
   assign cfg[1] = cfg1_ff;
   assign dn_src = test_rev ? du_s : dd_s;
   assign rx_line = aux_s[apt_pkg::PIN_RX];

   for (genvar c = 0; c < apt_pkg::NUM_CH; c++) begin : g_ch
      logic [7:0] dn_sh_ff, up_sh_ff, dn_hold_ff, up_hold_ff;
      logic ch_en;
      logic [3:0] bus_slot, tx_slot, rx_slot;

      assign ch_en = pcm_en & cfg[c][apt_pkg::CFG_EN_BIT];
      assign bus_slot = cfg[c][apt_pkg::CFG_BUS_LSB +: 4];
      assign tx_slot = cfg[c][apt_pkg::CFG_TX_LSB +: 4];
      assign rx_slot = cfg[c][apt_pkg::CFG_RX_LSB +: 4];

      always_ff @(posedge SYS_CLK or negedge rst_n) begin
         if (!rst_n) begin
            dn_sh_ff <= 8'hff;
            up_sh_ff <= 8'hff;
            dn_hold_ff <= 8'hff;
            up_hold_ff <= 8'hff;
         end else begin
            if (sample_ev && smp_slot == bus_slot) begin
               dn_sh_ff <= {dn_sh_ff[6:0], dn_src};
            end
            if (sample_ev && smp_slot == rx_slot) begin
               up_sh_ff <= {up_sh_ff[6:0], rx_line};
            end
            // Octets caught in one frame are sent in the next one.
            if (fsc_rise) begin
               dn_hold_ff <= dn_sh_ff;
               up_hold_ff <= up_sh_ff;
            end
         end
      end

      // At the sync edge the hold register is still loading, so bit 7 comes from the shifter.
      assign tx_hit[c] = ch_en & (drv_slot == tx_slot);
      assign tx_bit[c] = fsc_rise ? dn_sh_ff[~drv_bit] : dn_hold_ff[~drv_bit];
      assign bus_hit[c] = ch_en & (drv_slot == bus_slot);
      assign bus_bit[c] = fsc_rise ? up_sh_ff[~drv_bit] : up_hold_ff[~drv_bit];
   end

   // ****************************************
   // Line drivers
   // ****************************************
   logic tdm_tx_ff, bus_drv_ff, bus_bit_ff;

   // Idle transmit slots rest high so an unused line looks like all ones.
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         tdm_tx_ff <= 1'b1;
         bus_drv_ff <= 1'b0;
         bus_bit_ff <= 1'b1;
      end else if (drive_ev) begin
         tdm_tx_ff <= (|tx_hit) ? |(tx_hit & tx_bit) : 1'b1;
         bus_drv_ff <= |bus_hit;
         bus_bit_ff <= |(bus_hit & bus_bit);
      end
   end

   // The bus line is only driven inside our own slot, other talkers own the rest.
   assign SERIAL_UPSTREAM_DATA_OUT = bus_bit_ff;
   assign SERIAL_UPSTREAM_DATA_OE = bus_drv_ff & ~test_rev;
   assign SERIAL_DOWNSTREAM_DATA_OUT = bus_bit_ff;
   assign SERIAL_DOWNSTREAM_DATA_OE = bus_drv_ff & test_rev;

   // ****************************************
   // Frame sync and bit clock generator
   // ****************************************
   logic [7:0] fs_cnt_ff;
   logic fso_ff, bclk_ff, frame_or_bitclock_out;

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         fs_cnt_ff <= 8'h00;
         fso_ff <= 1'b0;
         bclk_ff <= 1'b0;
      end else begin
         if (dcl_rise) begin
            fs_cnt_ff <= (fs_cnt_ff == apt_pkg::FSO_DIV - 8'h01) ? 8'h00 : fs_cnt_ff + 8'h01;
         end
         fso_ff <= fs_cnt_ff < apt_pkg::FSO_HIGH;
         bclk_ff <= ~nxt_dcl_cnt[0];
      end
   end
   assign frame_or_bitclock_out = fb_bitclk ? bclk_ff : fso_ff;

   // ****************************************
   // Pin multiplexing
   // ****************************************
   logic [4:0] gp_out, gp_oe, pcm_sel, pcm_out, pin_out_ff, pin_oe_ff;

   // Open drain only ever pulls low; releasing the pin stands for a one.
   assign gp_out = out_ff & ~od_ff;
   assign gp_oe = dir_ff & (~od_ff | ~out_ff);
   assign pcm_sel = pcm_en ? apt_pkg::PCM_PINS : 5'h00;
   assign pcm_out = {2'h0, tdm_tx_ff, 1'b0, frame_or_bitclock_out};

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_out_ff <= 5'h00;
         pin_oe_ff <= 5'h00;
      end else begin
         pin_out_ff <= (pcm_sel & pcm_out) | (~pcm_sel & gp_out);
         pin_oe_ff <= (pcm_sel & apt_pkg::PCM_OE_PINS) | (~pcm_sel & gp_oe);
      end
   end
   assign AUX_PIN_OUT = pin_out_ff;
   assign AUX_PIN_OE = pin_oe_ff;

endmodule : apt_aux_pcm
`default_nettype wire

// [testbench/apt_aux_pcm_asserts.sv]
// Port-level checker for the aux pin and PCM port block.
`default_nettype none
module apt_aux_pcm_asserts (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Pins and interrupt
   input wire logic [4:0] AUX_PIN_OE,
   input wire logic SERIAL_DOWNSTREAM_DATA_OE,
   input wire logic SERIAL_UPSTREAM_DATA_OE,
   input wire logic IRQ_N
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Properties
   // ****
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N);
   wire logic acc = PSEL && PENABLE;
   wire logic bad_a = PADDR > apt_pkg::OFS_TOP_IRQ_STATUS;
   sequence s_rd_stat;
      acc && !PWRITE && PADDR == apt_pkg::OFS_TOP_IRQ_STATUS;
   endsequence
   sequence s_mask_all;
      acc && PWRITE && PADDR == apt_pkg::OFS_IRQ_MASK && PWDATA[7:6] == 2'h3;
   endsequence
   a_ready_const: assert property (PREADY) else $error("ready low");
   a_err_unmapped: assert property (acc && bad_a |-> PSLVERR) else $error("no slave error");
   a_err_mapped: assert property (acc && !bad_a && PADDR[1:0] == 2'h0 |-> !PSLVERR) else $error("false error");
   a_unmapped_zero: assert property (acc && !PWRITE && bad_a |-> PRDATA == 32'h0) else $error("unmapped data");
   a_stat_layout: assert property (s_rd_stat |-> PRDATA[31:8] == 24'h0 && PRDATA[5:0] == 6'h0)
      else $error("status layout");
   a_irq_shown: assert property (s_rd_stat ##0 PRDATA[7:6] != 2'h0 |-> !IRQ_N)
      else $error("irq released early");
   a_mask_quiet: assert property (s_mask_all |-> ##2 IRQ_N)
      else $error("masked irq shown");
   a_bus_oe_one: assert property (!(SERIAL_DOWNSTREAM_DATA_OE && SERIAL_UPSTREAM_DATA_OE))
      else $error("both bus lines driven");
   a_reset_quiet: assert property ($rose(RESET_N) |-> IRQ_N && AUX_PIN_OE == 5'h0 ##1 IRQ_N && AUX_PIN_OE == 5'h0)
      else $error("reset state");
endmodule : apt_aux_pcm_asserts
bind apt_aux_pcm apt_aux_pcm_asserts u_chk (
   .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .AUX_PIN_OE(AUX_PIN_OE), .SERIAL_DOWNSTREAM_DATA_OE(SERIAL_DOWNSTREAM_DATA_OE),
   .SERIAL_UPSTREAM_DATA_OE(SERIAL_UPSTREAM_DATA_OE), .IRQ_N(IRQ_N));
`default_nettype wire

// [testbench/apt_tdm_peer.sv]
// Behavioural TDM peripheral with the shared frame timing source.
`default_nettype none
module apt_tdm_peer #(
   parameter logic [3:0] RX_SLOT = 4'h5,
   parameter logic [3:0] TX_SLOT = 4'h3,
   parameter logic [3:0] BUS_SLOT = 4'h0,
   parameter logic [7:0] RX_OCT = 8'h00,
   parameter logic [7:0] DD_OCT = 8'h00,
   parameter logic [7:0] DU_OCT = 8'h00
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Line levels
   input wire logic tx_line,
   input wire logic dd_line,
   input wire logic du_line,
   // Driven timing and data
   output logic double_rate_bit_clock,
   output logic frame_sync,
   output logic rx_line,
   output logic dd_drv,
   output logic du_drv,
   // Octets caught last frame
   output logic [7:0] got_tx,
   output logic [7:0] got_dd,
   output logic [7:0] got_du
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Timing and data
   // ****
   logic [2:0] ph_ff;
   logic [7:0] cnt_ff;
   logic [7:0] s_tx_ff, s_dd_ff, s_du_ff;
   wire logic [3:0] slot = cnt_ff[7:4];
   wire logic [2:0] bp = ~cnt_ff[3:1];
   wire logic take = cnt_ff[0] && ph_ff == 3'h3;
   wire logic last = take && cnt_ff[3:1] == 3'h7;
   assign double_rate_bit_clock = ~ph_ff[2];
   assign frame_sync = cnt_ff < 8'h02;
   // Idle bits toggle so a stale value on a line cannot pass for data.
   assign rx_line = (slot == RX_SLOT) ? RX_OCT[bp] : cnt_ff[1];
   assign dd_drv = (slot == BUS_SLOT) ? DD_OCT[bp] : cnt_ff[1];
   assign du_drv = (slot == BUS_SLOT) ? DU_OCT[bp] : ~cnt_ff[1];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_ff <= 3'h0;
         cnt_ff <= 8'h00;
      end else begin
         ph_ff <= ph_ff + 3'h1;
         if (ph_ff == 3'h7) begin
            cnt_ff <= (cnt_ff == 8'hbf) ? 8'h00 : cnt_ff + 8'h01;
         end
         if (take) begin
            s_tx_ff <= {s_tx_ff[6:0], tx_line};
            s_dd_ff <= {s_dd_ff[6:0], dd_line};
            s_du_ff <= {s_du_ff[6:0], du_line};
         end
         if (last && slot == TX_SLOT) begin
            got_tx <= {s_tx_ff[6:0], tx_line};
         end
         if (last && slot == BUS_SLOT) begin
            got_dd <= {s_dd_ff[6:0], dd_line};
            got_du <= {s_du_ff[6:0], du_line};
         end
      end
   end
endmodule : apt_tdm_peer
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the aux pin and PCM port block.
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] RX_OCT = 8'ha5;
   localparam logic [7:0] DD_OCT = 8'h3c;
   localparam logic [7:0] DU_OCT = 8'hc6;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pcm_on = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq_n, dd_out, dd_oe, du_out, du_oe, double_rate_bit_clock, frame_sync, rx_line, dd_drv, du_drv;
   logic [4:0] pin_out, pin_oe;
   logic [4:0] gpio_in = 5'h1f;
   logic [7:0] got_tx, got_dd, got_du;
   int n_fail = 0;
   int tests_run = 0;
   // Pins resolve from the block's enables; undriven pins read the external level.
   wire logic [4:0] ext = {gpio_in[4:2], pcm_on ? rx_line : gpio_in[1], gpio_in[0]};
   wire logic [4:0] pin = (pin_oe & pin_out) | (~pin_oe & ext);
   wire logic dd_line = dd_oe ? dd_out : dd_drv;
   wire logic du_line = du_oe ? du_out : du_drv;
   apt_aux_pcm u_dut (
      .SYS_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .AUX_PIN_IN(pin), .AUX_PIN_OUT(pin_out), .AUX_PIN_OE(pin_oe),
      .DOUBLE_RATE_BIT_CLOCK(double_rate_bit_clock), .FRAME_SYNC(frame_sync),
      .SERIAL_DOWNSTREAM_DATA_IN(dd_line), .SERIAL_DOWNSTREAM_DATA_OUT(dd_out), .SERIAL_DOWNSTREAM_DATA_OE(dd_oe),
      .SERIAL_UPSTREAM_DATA_IN(du_line), .SERIAL_UPSTREAM_DATA_OUT(du_out), .SERIAL_UPSTREAM_DATA_OE(du_oe),
      .IRQ_N(irq_n));
   apt_tdm_peer #(.RX_OCT(RX_OCT), .DD_OCT(DD_OCT), .DU_OCT(DU_OCT)) u_peer (
      .clk(clk), .rst_n(rst_n), .tx_line(pin[2]), .dd_line(dd_line), .du_line(du_line),
      .double_rate_bit_clock(double_rate_bit_clock), .frame_sync(frame_sync), .rx_line(rx_line), .dd_drv(dd_drv), .du_drv(du_drv),
      .got_tx(got_tx), .got_dd(got_dd), .got_du(got_du));
   initial begin
      forever #10 clk = ~clk;
   end
   // ****
   // Tasks
   // ****
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      `CHK(r, x)
   endtask : rd
   task automatic t_reset;
      `CHK(irq_n, 1'b1)
      `CHK(pin_oe, 5'h00)
      rd(apt_pkg::OFS_GPIO_DIR, 32'h0);
      rd(apt_pkg::OFS_PCM_CTRL, 32'h0);
      rd(apt_pkg::OFS_CH1_CFG, 32'h1);
      rd(apt_pkg::OFS_IRQ_MASK, 32'hc0);
   endtask : t_reset
   task automatic t_gpio;
      wr(apt_pkg::OFS_GPIO_DIR, 32'h1f);
      wr(apt_pkg::OFS_GPIO_OUT, 32'h15);
      tick(2);
      `CHK(pin_oe, 5'h1f)
      `CHK(pin_out, 5'h15)
      wr(apt_pkg::OFS_GPIO_OD, 32'h18);
      tick(2);
      `CHK(pin_oe, 5'h0f)
      `CHK(pin_out, 5'h05)
      wr(apt_pkg::OFS_GPIO_OD, 32'h0);
      wr(apt_pkg::OFS_GPIO_DIR, 32'h0);
      gpio_in <= 5'h0a;
      tick(4);
      rd(apt_pkg::OFS_GPIO_IN, 32'h0a);
      wr(apt_pkg::OFS_GPIO_IN, 32'h1f);
      rd(apt_pkg::OFS_GPIO_IN, 32'h0a);
      rd(12'h028, 32'h0);
      gpio_in <= 5'h1f;
   endtask : t_gpio
   task automatic t_irq;
      wr(apt_pkg::OFS_IRQ_MODE, 32'h1);
      wr(apt_pkg::OFS_IRQ_MASK, 32'h0);
      rd(apt_pkg::OFS_TOP_IRQ_STATUS, 32'hc0);
      tick(2);
      `CHK(irq_n, 1'b1)
      gpio_in <= 5'h17;
      tick(8);
      `CHK(irq_n, 1'b0)
      rd(apt_pkg::OFS_TOP_IRQ_STATUS, 32'h40);
      gpio_in <= 5'h1f;
      tick(8);
      `CHK(irq_n, 1'b1)
      rd(apt_pkg::OFS_TOP_IRQ_STATUS, 32'h0);
      wr(apt_pkg::OFS_IRQ_MASK, 32'h80);
      gpio_in <= 5'h0f;
      tick(8);
      `CHK(irq_n, 1'b1)
      rd(apt_pkg::OFS_TOP_IRQ_STATUS, 32'h0);
      wr(apt_pkg::OFS_IRQ_MASK, 32'h0);
      tick(2);
      `CHK(irq_n, 1'b0)
      rd(apt_pkg::OFS_TOP_IRQ_STATUS, 32'h80);
      wr(apt_pkg::OFS_IRQ_MASK, 32'hc0);
      tick(2);
      `CHK(irq_n, 1'b1)
      wr(apt_pkg::OFS_IRQ_MASK, 32'h0);
      rd(apt_pkg::OFS_TOP_IRQ_STATUS, 32'h80);
      gpio_in <= 5'h1f;
      rd(apt_pkg::OFS_TOP_IRQ_STATUS, 32'h80);
      rd(apt_pkg::OFS_TOP_IRQ_STATUS, 32'h0);
      tick(2);
      `CHK(irq_n, 1'b1)
   endtask : t_irq
   task automatic t_pcm;
      int n;
      logic p;
      wr(apt_pkg::OFS_CH0_CFG, 32'h1530);
      pcm_on <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         wr(apt_pkg::OFS_PCM_CTRL, (m == 0) ? 32'h3 : 32'h1);
         tick(1600);
         `CHK(pin_oe[2:0], 3'h5)
         n = 0;
         p = pin_out[0];
         repeat (1536) begin
            @(posedge clk);
            if (pin_out[0] && !p) n++;
            p = pin_out[0];
         end
         `CHK(n, (m == 0) ? 96 : 1)
      end
      tick(4700);
      `CHK(got_tx, DD_OCT)
      `CHK(got_du, RX_OCT)
      wr(apt_pkg::OFS_PCM_CTRL, 32'h5);
      tick(4700);
      `CHK(got_tx, DU_OCT)
      `CHK(got_dd, RX_OCT)
      wr(apt_pkg::OFS_PCM_CTRL, 32'h0);
      pcm_on <= 1'b0;
      tick(3);
      `CHK(pin_oe, 5'h00)
   endtask : t_pcm
   task automatic summarize;
      if (n_fail == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   initial begin
      tick(6);
      rst_n <= 1'b1;
      tick(4);
      t_reset();
      t_gpio();
      t_irq();
      t_pcm();
      summarize();
   end
   // The whole run needs about 16000 cycles; the limit leaves ample margin.
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      $display("BAD %0t timeout", $time);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
